/* File: design/otp_pkg.sv */
// Shared types and timing constants for the OTP read controller
package otp_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    localparam int CLK_PERIOD_NS = 40;
    // Read timing, fastest grade, in ns
    localparam int ADDRESS_ACCESS_DELAY_NS = 70;
    localparam int CE_ACCESS_NS = 70;
    localparam int OE_ACCESS_NS = 30;
    localparam int OUTPUT_FLOAT_DELAY_NS = 20;
    localparam int OUTPUT_HOLD_TIME_NS = 0;
    // Longest access waits round up, float wait rounds up as a least time
    localparam int ACC_CYC = (ADDRESS_ACCESS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLOAT_CYC = (OUTPUT_FLOAT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OE_LAG_CYC = (CE_ACCESS_NS - OE_ACCESS_NS) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    localparam logic [ADDR_W-1:0] ID_MFR_ADDR = 19'h00000;
    localparam logic [ADDR_W-1:0] ID_DEV_ADDR = 19'h00001;

    typedef struct packed {
        logic valid;
        logic id_mode;
        logic [ADDR_W-1:0] addr;
    } otp_req_t;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
    } otp_rsp_t;

    typedef struct packed {
        logic [ADDR_W-1:0] byte_address_lines;
        logic id_select_high_voltage_line;
        logic chip_enable_n;
        logic output_enable_n;
    } otp_pins_t;
endpackage

/* File: design/otp_read_host.sv */
// Host controller that reads an OTP memory over its parallel pins
// Notes on behaviour
// RQ1: 19-bit address selects one of 512K bytes
// RQ2: Drive pins only with both enables low
// RQ3: Data valid 70 ns after address
// RQ4: Outputs float 20 ns after enable rises
// RQ5: Hold after change is zero ns
// RQ6: OE may lag CE by 40 ns
// RQ7: OE may lag address by 40 ns
// RQ8: ID mode: line nine raised, others low
// RQ9: ID with bit zero low gives maker
// RQ10: ID with bit zero high gives device
// RQ11: OE to data within 30 ns
// RQ12: Device read path is purely combinational
`timescale 1ns/1ps
`default_nettype none
module otp_read_host
    import otp_pkg::*;
#(
    parameter int ACC_CYCLES = ACC_CYC,
    parameter int FLOAT_CYCLES = FLOAT_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire otp_pkg::otp_req_t req,
    output logic req_ready,
    output otp_pkg::otp_rsp_t rsp,
    output otp_pkg::otp_pins_t pins,
    output logic data_bus_oe_n,
    input wire logic [otp_pkg::DATA_W-1:0] byte_data_outputs
);
    import otp_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ACCESS = 4'b0010,
        ST_FLOAT = 4'b0100,
        ST_DONE = 4'b1000
    } otp_state_t;

    typedef struct packed {
        otp_state_t st;
        logic ready;
        otp_rsp_t rsp;
        otp_pins_t pins;
        logic bus_oe_n;
    } otp_host_t;

    otp_host_t s_q;
    otp_host_t s_d;
    logic tmr_load;
    logic [CNT_W-1:0] tmr_count;
    logic tmr_done;

    otp_wait_timer #(.W(CNT_W)) u_timer (
        .clk(clk),
        .rst(rst),
        .load(tmr_load),
        .count(tmr_count),
        .done(tmr_done)
    );

    always_comb begin
        s_d = s_q;
        tmr_load = 1'b0;
        tmr_count = '0;
        s_d.rsp.valid = 1'b0;
        unique case (s_q.st)
            ST_IDLE: begin
                s_d.ready = 1'b1;
                if (req.valid && s_q.ready) begin
                    s_d.ready = 1'b0;
                    // ID access forces all other lines low, only bit zero picks byte
                    if (req.id_mode) begin
                        s_d.pins.byte_address_lines = req.addr[0] ? ID_DEV_ADDR
                                                                  : ID_MFR_ADDR; // [RQ8] [RQ9] [RQ10]
                        s_d.pins.id_select_high_voltage_line = 1'b1; // [RQ8]
                    end else begin
                        s_d.pins.byte_address_lines = req.addr; // [RQ1]
                        s_d.pins.id_select_high_voltage_line = 1'b0;
                    end
                    // Both enables drop together; no OE lag, so access is never stretched
                    s_d.pins.chip_enable_n = 1'b0; // [RQ6] [RQ7]
                    s_d.pins.output_enable_n = 1'b0; // [RQ2]
                    tmr_load = 1'b1;
                    tmr_count = CNT_W'(ACC_CYCLES); // [RQ3] [RQ11]
                    s_d.st = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                if (tmr_done) begin
                    // Device path is combinational, so sample after full access time
                    s_d.rsp.data = byte_data_outputs; // [RQ3] [RQ12]
                    s_d.pins.chip_enable_n = 1'b1;
                    s_d.pins.output_enable_n = 1'b1;
                    s_d.pins.id_select_high_voltage_line = 1'b0;
                    tmr_load = 1'b1;
                    tmr_count = CNT_W'(FLOAT_CYCLES); // [RQ4]
                    s_d.st = ST_FLOAT;
                end
            end
            ST_FLOAT: begin
                // Data pins must be released before the bus is reused
                if (tmr_done) begin
                    s_d.bus_oe_n = 1'b0; // [RQ2] [RQ4] [RQ5]
                    s_d.rsp.valid = 1'b1;
                    s_d.st = ST_DONE;
                end
            end
            ST_DONE: begin
                s_d.ready = 1'b1;
                s_d.st = ST_IDLE;
            end
        endcase
        // Shared bus is ours only while the memory is deselected
        if (s_d.st == ST_ACCESS) begin
            s_d.bus_oe_n = 1'b1; // [RQ2]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q.st <= ST_IDLE;
            s_q.ready <= 1'b0;
            s_q.rsp <= '0;
            s_q.pins.byte_address_lines <= '0;
            s_q.pins.id_select_high_voltage_line <= 1'b0;
            s_q.pins.chip_enable_n <= 1'b1;
            s_q.pins.output_enable_n <= 1'b1;
            s_q.bus_oe_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign req_ready = s_q.ready;
    assign rsp = s_q.rsp;
    assign pins = s_q.pins;
    assign data_bus_oe_n = s_q.bus_oe_n;
endmodule
`default_nettype wire

/* File: design/otp_wait_timer.sv */
// Down-counter used to time pin phases
`timescale 1ns/1ps
`default_nettype none
module otp_wait_timer #(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [W-1:0] count,
    output logic done
);
    logic [W-1:0] cnt_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= count;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end
    // Done must not look at load: the caller derives load from done
    assign done = (cnt_q == '0);
endmodule
`default_nettype wire

/* File: testbench/otp_mem_model.sv */
// Behavioural memory device on the far side of the pins
`timescale 1ns/1ps
`default_nettype none
module otp_mem_model
    import otp_pkg::*;
#(
    parameter logic [7:0] MFR = 8'h5a, // Arbitrary id value
    parameter logic [7:0] DEV = 8'ha5 // Arbitrary id value
) (
    input wire otp_pkg::otp_pins_t pins,
    output logic [7:0] dout
);
    logic [7:0] val;
    wire [7:0] arr_late;
    wire ce_late;
    wire oe_late;
    wire off_late;
    always_comb begin
        val = pins.byte_address_lines[7:0] ^ pins.byte_address_lines[18:11];
        if (pins.id_select_high_voltage_line) begin
            val = pins.byte_address_lines[0] ? DEV : MFR;
        end
    end
    // Array data settles one access time after the address, old data holds until then
    assign #(ADDRESS_ACCESS_DELAY_NS) arr_late = val;
    assign #(CE_ACCESS_NS) ce_late = !pins.chip_enable_n;
    assign #(OE_ACCESS_NS) oe_late = !pins.output_enable_n;
    // Either enable rising releases the pins after the float delay
    assign #(OUTPUT_FLOAT_DELAY_NS) off_late = pins.chip_enable_n || pins.output_enable_n;
    // Floating bus shows inverted data so a late sample cannot pass
    assign dout = (ce_late && oe_late && !off_late) ? arr_late : ~arr_late;
endmodule
`default_nettype wire

/* File: testbench/otp_read_host_sva.sv */
// Pin protocol checker for the read controller
`timescale 1ns/1ps
`default_nettype none
module otp_read_host_sva
    import otp_pkg::*;
#(
    parameter int ACC_CYCLES = ACC_CYC,
    parameter int FLOAT_CYCLES = FLOAT_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire otp_pkg::otp_req_t req,
    input wire logic req_ready,
    input wire otp_pkg::otp_rsp_t rsp,
    input wire otp_pkg::otp_pins_t pins,
    input wire logic data_bus_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_take;
        req.valid && req_ready;
    endsequence
    sequence s_on;
        !pins.chip_enable_n && !pins.output_enable_n;
    endsequence
    property p_addr;
        s_take ##0 !req.id_mode |=> pins.byte_address_lines == $past(req.addr);
    endproperty
    a_addr: assert property (p_addr) else $error("address not driven");
    property p_id;
        s_take ##0 req.id_mode |=> pins.id_select_high_voltage_line
            && pins.byte_address_lines == {18'h0, $past(req.addr[0])};
    endproperty
    a_id: assert property (p_id) else $error("id pins wrong");
    property p_en;
        s_take |=> s_on ##1 !req_ready;
    endproperty
    a_en: assert property (p_en) else $error("enables late");
    property p_bus;
        !data_bus_oe_n |-> pins.chip_enable_n && pins.output_enable_n;
    endproperty
    a_bus: assert property (p_bus) else $error("bus contention");
    property p_rsp;
        s_take |-> ##[5:7] rsp.valid;
    endproperty
    a_rsp: assert property (p_rsp) else $error("answer late");
    property p_stab;
        !pins.chip_enable_n ##1 !pins.chip_enable_n |-> $stable(pins.byte_address_lines);
    endproperty
    a_stab: assert property (p_stab) else $error("address moved");
    property p_flt;
        $rose(pins.chip_enable_n) |-> data_bus_oe_n;
    endproperty
    a_flt: assert property (p_flt) else $error("no float wait");
    property p_idoff;
        pins.id_select_high_voltage_line |-> !pins.chip_enable_n;
    endproperty
    a_idoff: assert property (p_idoff) else $error("id line idle");
endmodule
bind otp_read_host otp_read_host_sva #(.ACC_CYCLES(ACC_CYCLES), .FLOAT_CYCLES(FLOAT_CYCLES))
    otp_read_host_sva_i(.clk(clk), .rst(rst), .req(req), .req_ready(req_ready),
    .rsp(rsp), .pins(pins), .data_bus_oe_n(data_bus_oe_n));
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench for the read controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import otp_pkg::*;
    localparam logic [7:0] MFR = 8'h5a; // Arbitrary id value
    localparam logic [7:0] DEV = 8'ha5; // Arbitrary id value
    logic clk = 0;
    logic rst = 1;
    otp_req_t req = '0;
    logic req_ready, data_bus_oe_n;
    otp_rsp_t rsp;
    otp_pins_t pins;
    logic [7:0] dout;
    logic [7:0] exp_q[$];
    int n_mismatch = 0, checks_done = 0, cyc = 0;
    always #20 clk = ~clk;
    otp_read_host otp_read_host_i(.clk(clk), .rst(rst), .req(req), .req_ready(req_ready),
        .rsp(rsp), .pins(pins), .data_bus_oe_n(data_bus_oe_n), .byte_data_outputs(dout));
    otp_mem_model #(.MFR(MFR), .DEV(DEV)) otp_mem_model_i(.pins(pins), .dout(dout));
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Request stays up while not ready, so refused cycles are exercised too
    task automatic rd(input logic id, input logic [18:0] a);
        logic r;
        req <= '{1'b1, id, a};
        exp_q.push_back(id ? (a[0] ? DEV : MFR) : a[7:0] ^ a[18:11]);
        do begin
            @(negedge clk);
            r = req_ready;
            @(posedge clk);
        end while (r !== 1'b1);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc > 3000) begin
            n_mismatch++;
            close_out();
        end else if (rsp.valid === 1'b1) begin
            checks_done++;
            if (exp_q.size() == 0 || rsp.data !== exp_q[0]) begin
                n_mismatch++;
                $display("[FAIL] rsp.data exp %h got %h", exp_q[0], rsp.data);
            end
            if (exp_q.size() > 0) void'(exp_q.pop_front());
        end
    end
    initial begin
        int i;
        void'($urandom(15122));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(1'b1, 19'h00000);
        rd(1'b1, 19'h00001);
        $display("test id done");
        for (i = 0; i < 20; i++) rd(1'b0, 19'($urandom));
        rd(1'b0, 19'h7ffff);
        req <= '0;
        repeat (10) @(posedge clk);
        checks_done++;
        if (exp_q.size() != 0) begin
            n_mismatch++;
            $display("[FAIL] pending exp 0 got %0d", exp_q.size());
        end
        $display("test reads done");
        close_out();
    end
endmodule
`default_nettype wire
